// [core/mdsr_pkg.sv]
// Purpose: Shared constants for the motor driver status register bank
// Assumes: 16-bit serial word, 8-bit registers
// Notes: Field positions are bit indices within each 8-bit register
package mdsr_pkg;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 8;
    // Register offsets
    localparam logic [5:0] OFS_SUMMARY = 6'h00;
    localparam logic [5:0] OFS_THERMAL_OC = 6'h01;
    localparam logic [5:0] OFS_REG_IF = 6'h02;
    localparam logic [5:0] OFS_LAST_VALID = 6'h0C;
    // Reset value of every status register
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Summary register fields
    localparam int unsigned SUM_STALL = 7;
    localparam int unsigned SUM_STEPDOWN = 6;
    localparam int unsigned SUM_SERIAL = 5;
    localparam int unsigned SUM_OVERCURRENT = 4;
    localparam int unsigned SUM_NO_POR = 3;
    localparam int unsigned SUM_OVERVOLT = 2;
    localparam int unsigned SUM_THERMAL = 1;
    localparam int unsigned SUM_FAULT = 0;
    // Thermal / overcurrent register fields; bits 5..0 are C-hi..A-lo
    localparam int unsigned TOC_WARN = 7;
    localparam int unsigned TOC_SHUTDOWN = 6;
    // Regulator / interface register fields
    localparam int unsigned RIF_PARITY = 2;
    localparam int unsigned RIF_FRAME = 1;
    localparam int unsigned RIF_ADDR = 0;
    // Serial word layout
    localparam int unsigned WORD_RW = 15;
    localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_OVER = 5'h11;
endpackage

// [core/mdsr_status_regs.sv]
// Purpose: Read-only fault status bank read over the 16-bit serial port
// Assumes: Serial pins are sampled on sys_clk, which runs far above the serial clock
// Notes: Writes are accepted as frames; their data changes nothing here, but parity, frame and address errors still latch
`timescale 1ns/1ps
module mdsr_status_regs #(
    parameter int unsigned FRAME_LEN = mdsr_pkg::FRAME_BITS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sleep_pin_n,
    input wire logic fault_clear_bit,
    input wire logic rotor_stall_det,
    input wire logic stepdown_fault_det,
    input wire logic supply_por_det,
    input wire logic supply_overvoltage_det,
    input wire logic thermal_warning_det,
    input wire logic thermal_shutdown_det,
    input wire logic [5:0] overcurrent_det,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    output logic [7:0] summary_fault_status,
    output logic [7:0] thermal_overcurrent_status,
    output logic [7:0] regulator_interface_status
);
    import mdsr_pkg::*;

    // Shift counter and reply layout only serve the 16-bit word
    if (FRAME_LEN != FRAME_BITS) begin : g_bad_frame_len
        $error("FRAME_LEN must be 16");
    end

    typedef struct packed {
        logic sclk_q;
        logic cs_n_q;
        logic sleep_q;
        logic [4:0] cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic rotor_stall_flag;
        logic stepdown_fault_flag;
        logic no_power_up_reset_flag;
        logic supply_overvoltage_flag;
        logic thermal_warning_flag;
        logic thermal_shutdown_flag;
        logic [5:0] switch_oc;
        logic parity_err;
        logic frame_err;
        logic addr_err;
    } mdsr_state_s;

    mdsr_state_s st;
    mdsr_state_s next_st;
    logic clear_cmd;
    logic sclk_fall;
    logic sclk_rise;
    logic frame_start;
    logic frame_end;
    logic [7:0] sel_data;

    assign clear_cmd = fault_clear_bit | (sleep_pin_n & ~st.sleep_q);
    assign sclk_fall = st.sclk_q & ~spi_sclk & ~spi_cs_n;
    assign sclk_rise = ~st.sclk_q & spi_sclk & ~spi_cs_n;
    assign frame_start = st.cs_n_q & ~spi_cs_n;
    assign frame_end = ~st.cs_n_q & spi_cs_n;

    assign summary_fault_status[SUM_STALL] = st.rotor_stall_flag;
    assign summary_fault_status[SUM_STEPDOWN] = st.stepdown_fault_flag;
    assign summary_fault_status[SUM_SERIAL] = st.parity_err | st.frame_err | st.addr_err;
    assign summary_fault_status[SUM_OVERCURRENT] = |st.switch_oc;
    assign summary_fault_status[SUM_NO_POR] = st.no_power_up_reset_flag;
    assign summary_fault_status[SUM_OVERVOLT] = st.supply_overvoltage_flag;
    assign summary_fault_status[SUM_THERMAL] = st.thermal_warning_flag
        | st.thermal_shutdown_flag;
    assign summary_fault_status[SUM_FAULT] = |{summary_fault_status[7:4],
        summary_fault_status[2:1]};
    assign thermal_overcurrent_status = {st.thermal_warning_flag,
        st.thermal_shutdown_flag, st.switch_oc};
    assign regulator_interface_status = {5'h00, st.parity_err, st.frame_err, st.addr_err};

    // Control registers live elsewhere; from this bank they read as zero
    always_comb begin
        case (st.rx[5:0])
            OFS_SUMMARY: sel_data = summary_fault_status;
            OFS_THERMAL_OC: sel_data = thermal_overcurrent_status;
            OFS_REG_IF: sel_data = regulator_interface_status;
            default: sel_data = 8'h00;
        endcase
    end

    assign spi_sdo = st.tx[15];
    assign spi_sdo_oe_n = spi_cs_n;

    always_comb begin
        next_st = st;
        next_st.sclk_q = spi_sclk;
        next_st.cs_n_q = spi_cs_n;
        next_st.sleep_q = sleep_pin_n;
        // Hardware set wins over a clear landing in the same cycle
        next_st.rotor_stall_flag = rotor_stall_det | (st.rotor_stall_flag & ~clear_cmd);
        next_st.thermal_shutdown_flag = thermal_shutdown_det
            | (st.thermal_shutdown_flag & ~clear_cmd);
        next_st.switch_oc = overcurrent_det | (st.switch_oc & {6{~clear_cmd}});
        next_st.parity_err = st.parity_err & ~clear_cmd;
        next_st.frame_err = st.frame_err & ~clear_cmd;
        next_st.addr_err = st.addr_err & ~clear_cmd;
        next_st.stepdown_fault_flag = stepdown_fault_det;
        next_st.supply_overvoltage_flag = supply_overvoltage_det;
        next_st.thermal_warning_flag = thermal_warning_det;
        // Cleared by a supply reset, re-armed only by a clear command
        if (supply_por_det) begin
            next_st.no_power_up_reset_flag = 1'b0;
        end else if (clear_cmd) begin
            next_st.no_power_up_reset_flag = 1'b1;
        end
        if (frame_start) begin
            next_st.cnt = 5'h00;
            next_st.tx = {summary_fault_status, 8'h00};
        end
        if (sclk_fall) begin
            next_st.rx = {st.rx[14:0], spi_sdi};
            if (st.cnt != CNT_OVER) begin
                next_st.cnt = st.cnt + 5'h01;
            end
        end
        // First rising edge keeps the MSB already presented at select
        if (sclk_rise && st.cnt != 5'h00) begin
            if (st.cnt == CNT_ADDR_DONE) begin
                // Last status bit still goes out before the register byte
                next_st.tx = {st.tx[14], sel_data, 7'h00};
            end else begin
                next_st.tx = {st.tx[14:0], 1'b0};
            end
        end
        if (frame_end) begin
            if (st.cnt != CNT_FULL) begin
                next_st.frame_err = 1'b1;
            end else begin
                // Parity over the full word must be even
                if (^st.rx) begin
                    next_st.parity_err = 1'b1;
                end
                if (st.rx[14:9] > OFS_LAST_VALID) begin
                    next_st.addr_err = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
            st.cs_n_q <= 1'b1;
            st.sleep_q <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    sequence s_short_frame;
        (~st.cs_n_q & spi_cs_n) && (st.cnt != CNT_FULL);
    endsequence
    sequence s_clear_no_cond;
        clear_cmd && !thermal_shutdown_det;
    endsequence

    property p_reset_zero;
        @(posedge sys_clk) $past(reset) |-> summary_fault_status == STATUS_RESET
            && thermal_overcurrent_status == STATUS_RESET
            && regulator_interface_status == STATUS_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");
    property p_stall;
        @(posedge sys_clk) disable iff (reset)
            rotor_stall_det |=> summary_fault_status[SUM_STALL] && summary_fault_status[SUM_FAULT];
    endproperty
    a_stall: assert property (p_stall) else $error("stall not flagged");
    property p_ots_hold;
        @(posedge sys_clk) disable iff (reset)
            st.thermal_shutdown_flag && !clear_cmd |=> thermal_overcurrent_status[TOC_SHUTDOWN];
    endproperty
    a_ots_hold: assert property (p_ots_hold) else $error("shutdown flag lost");
    property p_ots_clear;
        @(posedge sys_clk) disable iff (reset)
            s_clear_no_cond |=> !thermal_overcurrent_status[TOC_SHUTDOWN];
    endproperty
    a_ots_clear: assert property (p_ots_clear) else $error("shutdown flag not cleared");
    property p_por;
        @(posedge sys_clk) disable iff (reset)
            supply_por_det |=> !summary_fault_status[SUM_NO_POR];
    endproperty
    a_por: assert property (p_por) else $error("power-up reset not shown");
    property p_oc_lo;
        @(posedge sys_clk) disable iff (reset)
            overcurrent_det[0] |=> thermal_overcurrent_status[0]
                && summary_fault_status[SUM_OVERCURRENT];
    endproperty
    a_oc_lo: assert property (p_oc_lo) else $error("overcurrent not flagged");
    property p_thermal;
        @(posedge sys_clk) disable iff (reset)
            thermal_warning_det |=> summary_fault_status[SUM_THERMAL]
                && thermal_overcurrent_status[TOC_WARN];
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal warning not flagged");
    property p_frame_err;
        @(posedge sys_clk) disable iff (reset)
            s_short_frame |=> summary_fault_status[SUM_SERIAL];
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("short frame not flagged");
    property p_first_bit;
        @(posedge sys_clk) disable iff (reset)
            (st.cs_n_q & ~spi_cs_n) |=> spi_sdo == $past(summary_fault_status[SUM_STALL])
                && !spi_sdo_oe_n;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("status byte not first");
    property p_data_byte;
        @(posedge sys_clk) disable iff (reset)
            sclk_rise && st.cnt == CNT_ADDR_DONE |=> st.tx[14:7] == $past(sel_data)
                && spi_sdo == $past(st.tx[14]);
    endproperty
    a_data_byte: assert property (p_data_byte) else $error("register byte misplaced");
endmodule

// [dv/mdsr_spi_host.sv]
// Purpose: Behavioural serial controller that reads and writes the status bank
// Assumes: Each serial clock level lasts two sys_clk cycles
// Notes: Bit count per frame is chosen per call so bad frames can be made
`timescale 1ns/1ps
module mdsr_spi_host (
    input wire logic sys_clk,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe_n,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_sdi
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        spi_cs_n = 1'b0;
        wait_clk(2);
        for (int i = 0; i < n; i++) begin
            spi_sdi = (i < 16) ? w[15 - i] : 1'b0;
            spi_sclk = 1'b1;
            wait_clk(2);
            if (i < 16) r[15 - i] = spi_sdo_oe_n ? 1'bx : spi_sdo;
            spi_sclk = 1'b0;
            wait_clk(2);
        end
        spi_cs_n = 1'b1;
        // Released data line must not keep looking valid
        spi_sdi = ~spi_sdi;
        wait_clk(3);
    endtask
endmodule

// [dv/motor_driver_status_registers_tb.sv]
// Purpose: Self-checking bench for the fault status bank
// Assumes: Flags settle within two cycles of their cause
// Notes: Detector inputs are driven as one vector, bit 11 first
`timescale 1ns/1ps
module motor_driver_status_registers_tb;
    import mdsr_pkg::*;
    localparam logic [15:0] EW [7] = '{16'h9A00, 16'h8700, 16'h8100, 16'h8100, 16'h8000,
        16'h00FF, 16'h9900};
    localparam int EN [7] = '{16, 16, 15, 17, 16, 16, 16};
    localparam logic [7:0] ER [7] = '{8'h01, 8'h00, 8'h02, 8'h02, 8'h04, 8'h00, 8'h00};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic sleep_pin_n = 1'b1;
    logic fault_clear_bit = 1'b0;
    logic [11:0] det = 12'h000;
    logic [11:0] lat;
    logic cs_n, sclk, sdi, sdo, sdo_oe_n;
    logic [7:0] sum, toc, rif;
    logic [15:0] rep;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    mdsr_status_regs dut (.sys_clk(sys_clk), .reset(reset), .sleep_pin_n(sleep_pin_n),
        .fault_clear_bit(fault_clear_bit), .rotor_stall_det(det[11]),
        .stepdown_fault_det(det[10]), .supply_por_det(det[9]), .supply_overvoltage_det(det[8]),
        .thermal_warning_det(det[7]), .thermal_shutdown_det(det[6]), .overcurrent_det(det[5:0]),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe_n(sdo_oe_n),
        .summary_fault_status(sum), .thermal_overcurrent_status(toc),
        .regulator_interface_status(rif));
    mdsr_spi_host host (.sys_clk(sys_clk), .spi_sdo(sdo), .spi_sdo_oe_n(sdo_oe_n),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi));
    function automatic logic [7:0] esum(input logic [11:0] d);
        return {d[11], d[10], 1'b0, |d[5:0], ~d[9], d[8], |d[7:6], |(d & 12'hDFF)};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] r);
        host.xfer({1'b1, a, ^{1'b1, a}, 8'h00}, 16, r);
    endtask
    // Both clear paths are used so neither can hide behind the other
    task automatic clr(input logic by_sleep);
        if (by_sleep) begin
            sleep_pin_n = 1'b0;
            tick(1);
            sleep_pin_n = 1'b1;
        end else begin
            fault_clear_bit = 1'b1;
            tick(1);
            fault_clear_bit = 1'b0;
        end
        tick(3);
    endtask
    task automatic results();
        $display("TB: compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        tick(5);
        reset = 1'b0;
        tick(2);
        chk({sum, toc}, 16'h0000);
        chk({8'h00, rif}, 16'h0000);
        for (int a = 0; a < 3; a++) begin
            rd(a[5:0], rep);
            chk(rep, 16'h0000);
        end
        $display("TB: test reset values done");
        clr(1'b0);
        chk({sum, toc}, 16'h0800);
        for (int k = 0; k < 12; k++) begin
            det = 12'h800 >> k;
            tick(2);
            chk({sum, toc}, {esum(det), det[7:0]});
            rd(OFS_THERMAL_OC, rep);
            chk(rep, {esum(det), det[7:0]});
            det = 12'h000;
            tick(2);
            lat = (12'h800 >> k) & 12'hA7F;
            chk({sum, toc}, {esum(lat), lat[7:0]});
            clr(k[0]);
            chk({sum, toc}, 16'h0800);
        end
        $display("TB: test flag mapping done");
        for (int i = 0; i < 7; i++) begin
            host.xfer(EW[i], EN[i], rep);
            if (ER[i] === 8'h00) chk(rep, {8'h08, EW[i][15] ? 8'h00 : 8'h08});
            chk({sum, rif}, {(ER[i] === 8'h00) ? 8'h08 : 8'h29, ER[i]});
            clr(i[0]);
        end
        chk({sum, rif}, 16'h0800);
        $display("TB: test serial errors done");
        // Reset in mid-run must wipe latched and live flags alike
        host.xfer(16'h8100, 15, rep);
        det = 12'hFFF;
        tick(2);
        reset = 1'b1;
        det = 12'h000;
        tick(2);
        reset = 1'b0;
        tick(1);
        chk({sum, toc}, 16'h0000);
        chk({8'h00, rif}, 16'h0000);
        $display("TB: test mid-run reset done");
        results();
    end
endmodule
